/* File: switch_cycle_consts.svh */
`ifndef SWITCH_CYCLE_CONSTS_SVH
`define SWITCH_CYCLE_CONSTS_SVH
// Clock rate and oscillator periods
`define CLK_HZ 125000000
`define BASE_LOW_HZ 44000
`define BASE_HIGH_HZ 130000
`define PERIOD_LOW (`CLK_HZ / `BASE_LOW_HZ)
`define PERIOD_HIGH (`CLK_HZ / `BASE_HIGH_HZ)
// Maximum duty window, percent
`define MAX_DUTY_PCT 67
// Power-up delay in microseconds (0.3 ms)
`define POWER_UP_US 300
`define POWER_UP_CYCLES ((`POWER_UP_US * (`CLK_HZ / 1000000)))
// Default blanking count in clocks
`define BLANK_DEFAULT 16'h0020
// Enable sense thresholds in microamps (nominal, lowered)
`define EN_TRIP_UA 8'h32
`define EN_RELEASE_UA 8'h28
`endif

/* File: switch_cycle_pkg.sv */
package switch_cycle_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ON,
        ST_OFF
    } cycle_state_t;

    typedef struct packed {
        logic cur_limit;
        logic supply_low;
        logic supply_ok;
        logic over_temp;
        logic temp_cool;
        logic line_ok;
    } sense_t;
endpackage : switch_cycle_pkg

/* File: on_off_switch_cycle_controller.sv */
// Contract
// - Current limit while on turns switch off for the rest of the cycle.
// - Current limit ignored during blanking after each turn-on.
// - Enabled cycle turns switch on at the cycle start.
// - Switch forced off at end of max duty window.
// - Started cycle completes; enable changes ignored until next start.
// - Oscillator runs always; enable sampled once per cycle start.
// - Low sampled enable skips the cycle, resample next start.
// - Enable pull-down threshold 50 uA, drops to 40 uA once tripped.
// - Base frequency 44 kHz low-power, 130 kHz high-power variant.
// - Switching starts after 0.3 ms power-up delay.
// - On power-down, switching stops and switch stays off, glitch free.
// - Max duty window high about 67 percent of every cycle.
// - Low-frequency variant doubles frequency while skipping cycles.
// - Undervoltage off below 5.1 V, back on at 5.8 V.
// - Thermal off above 135 C, back on after 70 C fall.
`timescale 1ns/100ps
`include "switch_cycle_consts.svh"
module on_off_switch_cycle_controller
    import switch_cycle_pkg::*;
#(
    parameter int POWER_UP_COUNT = `POWER_UP_CYCLES,
    parameter bit HIGH_POWER = 1'b0
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Feedback enable sense: pull-down current in microamps
    input wire logic [7:0] enable_pulldown_ua,
    // Analog flags
    input wire sense_t sense,
    // Blanking length in clocks
    input wire logic [15:0] turn_on_blanking_time,
    // Outputs
    output logic switch_drive,
    output logic max_duty_window,
    output logic cycle_start,
    output logic skipping
);
    localparam logic [15:0] PER_BASE = HIGH_POWER ? 16'(`PERIOD_HIGH) : 16'(`PERIOD_LOW);

    function automatic logic [15:0] duty_end(input logic [15:0] per);
        logic [31:0] p;
        p = 32'(per) * 32'(`MAX_DUTY_PCT);
        duty_end = 16'(p / 32'd100);
    endfunction : duty_end

    // Two-flop synchronisers for the enable sense and analog flag inputs
    logic [7:0] en_s1, en_s2;
    sense_t sn_s1, sn_s2;
    always_ff @(posedge ref_clk) begin
        en_s1 <= enable_pulldown_ua;
        en_s2 <= en_s1;
        sn_s1 <= sense;
        sn_s2 <= sn_s1;
    end

    // Enable sense hysteresis
    logic en_low, next_en_low;
    always_comb begin
        next_en_low = en_low;
        if (!en_low && en_s2 > `EN_TRIP_UA) begin
            next_en_low = 1'b1;
        end else if (en_low && en_s2 < `EN_RELEASE_UA) begin
            next_en_low = 1'b0;
        end
    end

    // Protection latches
    logic uv_off, next_uv_off, ot_off, next_ot_off;
    always_comb begin
        next_uv_off = uv_off;
        if (sn_s2.supply_low) begin
            next_uv_off = 1'b1;
        end else if (sn_s2.supply_ok) begin
            next_uv_off = 1'b0;
        end
        next_ot_off = ot_off;
        if (sn_s2.over_temp) begin
            next_ot_off = 1'b1;
        end else if (sn_s2.temp_cool) begin
            next_ot_off = 1'b0;
        end
    end

    // Power-up delay counter
    logic [31:0] pu_cnt, next_pu_cnt;
    logic pu_done, next_pu_done;
    always_comb begin
        next_pu_cnt = pu_cnt;
        next_pu_done = pu_done;
        if (!pu_done) begin
            if (pu_cnt >= 32'(POWER_UP_COUNT - 1)) begin
                next_pu_done = 1'b1;
            end else begin
                next_pu_cnt = pu_cnt + 32'd1;
            end
        end
    end

    // Oscillator; period halves while skipping on the low-frequency variant
    logic [15:0] osc, next_osc, per, next_per;
    logic next_cycle_start, next_max_duty, next_skipping;
    logic start_ok;
    always_comb begin
        next_cycle_start = 1'b0;
        next_per = per;
        next_skipping = skipping;
        if (osc >= per - 16'h0001) begin
            next_osc = 16'h0000;
            next_cycle_start = 1'b1;
        end else begin
            next_osc = osc + 16'h0001;
        end
        next_max_duty = (next_osc < duty_end(next_per));
        if (cycle_start) begin
            next_skipping = !start_ok;
            next_per = (!start_ok && !HIGH_POWER) ? (PER_BASE >> 1) : PER_BASE;
            next_max_duty = (next_osc < duty_end(next_per));
        end
    end

    // Cycle decision uses enable state at the cycle start only
    assign start_ok = !en_low && !uv_off && !ot_off && pu_done && sn_s2.line_ok;

    // Switch state machine
    cycle_state_t state, next_state;
    logic [15:0] blank, next_blank;
    logic next_drive;
    always_comb begin
        next_state = state;
        next_blank = blank;
        next_drive = switch_drive;
        case (state)
            ST_IDLE, ST_OFF: begin
                next_drive = 1'b0;
                if (cycle_start) begin
                    if (start_ok) begin
                        next_state = ST_ON;
                        next_drive = 1'b1;
                        next_blank = turn_on_blanking_time;
                    end else begin
                        next_state = ST_OFF;
                    end
                end
            end
            ST_ON: begin
                // Enable is not looked at here, so the cycle always completes
                if (blank != 16'h0000) begin
                    next_blank = blank - 16'h0001;
                end
                if (!max_duty_window) begin
                    next_state = ST_OFF;
                    next_drive = 1'b0;
                end else if (blank == 16'h0000 && sn_s2.cur_limit) begin
                    next_state = ST_OFF;
                    next_drive = 1'b0;
                end else if (!sn_s2.line_ok || uv_off || ot_off) begin
                    next_state = ST_OFF;
                    next_drive = 1'b0;
                end
                if (cycle_start) begin
                    next_state = ST_OFF;
                    next_drive = 1'b0;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_drive = 1'b0;
            end
        endcase
    end

    // Enable sense register; treated as low until the pin is seen released
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            en_low <= 1'b1;
        end else begin
            en_low <= next_en_low;
        end
    end

    // Protection registers; supply counts as low until supply_ok is seen
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            uv_off <= 1'b1;
            ot_off <= 1'b0;
        end else begin
            uv_off <= next_uv_off;
            ot_off <= next_ot_off;
        end
    end

    // Power-up delay registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pu_cnt <= 32'h00000000;
            pu_done <= 1'b0;
        end else begin
            pu_cnt <= next_pu_cnt;
            pu_done <= next_pu_done;
        end
    end

    // Oscillator registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            osc <= 16'h0000;
            per <= PER_BASE;
            cycle_start <= 1'b0;
            max_duty_window <= 1'b0;
            skipping <= 1'b0;
        end else begin
            osc <= next_osc;
            per <= next_per;
            cycle_start <= next_cycle_start;
            max_duty_window <= next_max_duty;
            skipping <= next_skipping;
        end
    end

    // Switch state registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= ST_IDLE;
            blank <= 16'h0000;
            switch_drive <= 1'b0;
        end else begin
            state <= next_state;
            blank <= next_blank;
            switch_drive <= next_drive;
        end
    end
endmodule : on_off_switch_cycle_controller

/* File: opto_feedback.sv */
`timescale 1ns/100ps
module opto_feedback (
    // Clock and demand
    input wire logic ref_clk,
    input wire logic above_target,
    // Enable pin current
    output logic [7:0] enable_pulldown_ua
);
    logic [7:0] next_pull;
    // A lit opto sinks far past the trip point; a dark one leaves the pin free
    always_comb begin
        next_pull = above_target ? 8'h3C : 8'h00;
    end
    always_ff @(posedge ref_clk) begin
        enable_pulldown_ua <= next_pull;
    end
endmodule : opto_feedback

/* File: switch_cycle_checker.sv */
`timescale 1ns/100ps
module switch_cycle_checker
    import switch_cycle_pkg::*;
#(
    parameter int POWER_UP_COUNT = 20,
    parameter bit HIGH_POWER = 1'b0
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] enable_pulldown_ua,
    input wire sense_t sense,
    input wire logic [15:0] turn_on_blanking_time,
    input wire logic switch_drive,
    input wire logic max_duty_window,
    input wire logic cycle_start,
    input wire logic skipping
);
    logic [11:0] per_cnt, next_per_cnt;
    logic [15:0] on_cnt, next_on_cnt;
    always_comb begin
        next_per_cnt = cycle_start ? 12'h001 : (per_cnt != 12'h000 ? per_cnt + 12'h001 : 12'h000);
        next_on_cnt = switch_drive ? on_cnt + 16'h0001 : 16'h0000;
        if (rst) begin
            next_per_cnt = 12'h000;
            next_on_cnt = 16'h0000;
        end
    end
    always_ff @(posedge ref_clk) begin
        per_cnt <= next_per_cnt;
        on_cnt <= next_on_cnt;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_turn_on_start: assert property ($rose(switch_drive) |-> $past(cycle_start))
        else $error("switch rose without cycle start");
    a_window_end: assert property ($fell(max_duty_window) |=> !switch_drive)
        else $error("switch on past duty window");
    a_stay_off: assert property (!switch_drive && !cycle_start |=> !switch_drive)
        else $error("switch restarted within a cycle");
    a_period_len: assert property (cycle_start && per_cnt != 12'h000 |->
        (HIGH_POWER ? per_cnt == 12'h3C1 : per_cnt inside {12'h58C, 12'hB18})) else $error("bad period");
    a_blank_hold: assert property ($fell(switch_drive) && max_duty_window |->
        on_cnt >= turn_on_blanking_time) else $error("pulse ended inside blanking");
    a_limit_ends: assert property (sense.cur_limit [*3] ##0
        (switch_drive && on_cnt > turn_on_blanking_time + 16'h0002) |-> ##[1:3] !switch_drive)
        else $error("current limit ignored");
    a_skip_low: assert property ((enable_pulldown_ua > 8'h32) [*4] ##0 cycle_start |=> !switch_drive)
        else $error("switched while enable low");
    a_fault_off: assert property ((sense.supply_low || sense.over_temp || !sense.line_ok) [*5] |->
        !switch_drive) else $error("switched under fault");
    cover property (cycle_start ##1 switch_drive);
    cover property ($fell(switch_drive) && max_duty_window);
    cover property (skipping && cycle_start);
endmodule : switch_cycle_checker
bind on_off_switch_cycle_controller switch_cycle_checker #(.POWER_UP_COUNT(POWER_UP_COUNT),
    .HIGH_POWER(HIGH_POWER)) u_switch_cycle_checker (.ref_clk, .rst, .enable_pulldown_ua, .sense,
    .turn_on_blanking_time, .switch_drive, .max_duty_window, .cycle_start, .skipping);

/* File: tb.sv */
`timescale 1ns/100ps
module tb;
    import switch_cycle_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic above = 1'b0;
    logic [7:0] pull_ua;
    sense_t sense = 6'h0B;
    sense_t faults [3] = '{6'h13, 6'h0D, 6'h0A};
    logic sw, win, cs, skp, exp, exp_next;
    int failures = 0;
    int num_checks = 0;
    int n;
    always #4 ref_clk = ~ref_clk;
    opto_feedback u_opto_feedback (.ref_clk, .above_target(above), .enable_pulldown_ua(pull_ua));
    on_off_switch_cycle_controller #(.POWER_UP_COUNT(20), .HIGH_POWER(1'b0)) u_on_off_switch_cycle_controller (
        .ref_clk, .rst, .enable_pulldown_ua(pull_ua), .sense, .turn_on_blanking_time(16'h003C),
        .switch_drive(sw), .max_duty_window(win), .cycle_start(cs), .skipping(skp));
    function automatic logic want_on(input logic hi);
        return !hi;
    endfunction : want_on
    task automatic check(input logic seen, input logic want);
        num_checks++;
        if (seen !== want) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask : check
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    // Bounded by one full slow period plus margin
    task automatic next_start();
        n = 0;
        while (cs !== 1'b1) begin
            tick(1);
            if (++n > 3000) begin
                failures++;
                complete_run();
            end
        end
    endtask : next_start
    initial begin
        void'($urandom(24));
        exp = 1'b1;
        tick(16);
        rst = 1'b0;
        for (int i = 0; i < 20; i++) begin
            next_start();
            tick(1);
            if (i > 0) check(sw, exp);
            above = 1'($urandom);
            exp_next = want_on(above);
            sense.cur_limit = 1'($urandom);
            tick(40);
            check(sw, exp);
            tick(80);
            check(sw, exp && !sense.cur_limit);
            check(skp, !exp);
            check(win, 1'b1);
            exp = exp_next;
        end
        $display("random cycles done");
        for (int f = 0; f < 3; f++) begin
            above = 1'b1;
            sense.cur_limit = 1'b0;
            repeat (2) begin
                next_start();
                tick(1);
            end
            sense = faults[f];
            above = 1'b0;
            next_start();
            tick(1);
            check(sw, 1'b0);
            sense = 6'h0B;
        end
        $display("fault cycles done");
        complete_run();
    end
endmodule : tb
